// [hdl/rgl_guard.sv]
`timescale 1ns/1ns
`default_nettype none
module rgl_guard
	import rgl_pkg::*;
#(
	parameter int UNIT_CYC = DLY_UNIT_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        enable,
	input  wire logic        violation,
	input  wire logic [31:0] delay_units,
	input  wire logic        clear,
	output logic             tripped
);
	import rgl_pkg::*;

	logic [13:0] pre_q;
	logic [31:0] units_q;
	wire         active   = enable & violation;
	// Unit length must fit the 14-bit prescaler
	wire         unit_tick = (pre_q == 14'(UNIT_CYC - 1));
	wire         expire   = active & unit_tick & (units_q + 32'h1 >= delay_units);

	// ==========================================================
	// Persistence timer restarts when the condition drops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_q   <= 14'h0;
			units_q <= 32'h0;
		end else if (!active) begin
			pre_q   <= 14'h0;
			units_q <= 32'h0;
		end else if (unit_tick) begin
			pre_q   <= 14'h0;
			units_q <= units_q + 32'h1;
		end else begin
			pre_q <= pre_q + 14'h1;
		end
	end

	// Trip wins over a clear in the same cycle; stays until cleared
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			tripped <= 1'b0;
		else if (expire)
			tripped <= 1'b1;
		else if (clear)
			tripped <= 1'b0;
	end

endmodule : rgl_guard
`default_nettype wire

// [hdl/rgl_top.sv]
`timescale 1ns/1ns
`default_nettype none
module rgl_top
	import rgl_pkg::*;
#(
	parameter logic [31:0] HV_DEF = HV_DEF_MILLI,
	parameter logic [31:0] LV_DEF = LV_DEF_MILLI,
	parameter logic [31:0] HF_DEF = HF_DEF_MILLI,
	parameter logic [31:0] LF_DEF = LF_DEF_MILLI,
	// Cycles per delay unit; only a bench shortens it
	parameter int          UNIT_CYC = DLY_UNIT_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic [7:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic [31:0] VOLT_RMS_MILLI,
	input  wire logic [31:0] FREQ_MILLI,
	input  wire logic        LOAD_OPTION_FITTED,
	input  wire logic        TRACKER_LOCKED,
	input  wire logic        FAST_SYNC_LOCKED,
	output logic             OUTPUT_ENABLE,
	output logic             LOAD_ACTIVE,
	output logic [1:0]       LOAD_MODE,
	output logic             FAST_SYNC_SEL,
	output logic [2:0]       RECT_EMU_EN,
	output logic             LOAD_CURRENT_ZERO
);
	import rgl_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [1:0] fit_s_q;
	logic [1:0] trk_s_q;
	logic [1:0] fst_s_q;
	// Torn measurement words last one cycle and only restart a timer
	logic [31:0] volt_s1_q;
	logic [31:0] volt_s2_q;
	logic [31:0] freq_s1_q;
	logic [31:0] freq_s2_q;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			fit_s_q   <= 2'h0;
			trk_s_q   <= 2'h0;
			fst_s_q   <= 2'h0;
			volt_s1_q <= 32'h0;
			volt_s2_q <= 32'h0;
			freq_s1_q <= 32'h0;
			freq_s2_q <= 32'h0;
		end else begin
			fit_s_q   <= {fit_s_q[0], LOAD_OPTION_FITTED};
			trk_s_q   <= {trk_s_q[0], TRACKER_LOCKED};
			fst_s_q   <= {fst_s_q[0], FAST_SYNC_LOCKED};
			volt_s1_q <= VOLT_RMS_MILLI;
			volt_s2_q <= volt_s1_q;
			freq_s1_q <= FREQ_MILLI;
			freq_s2_q <= freq_s1_q;
		end
	end

	// ==========================================================
	// Helpers
	function automatic logic [31:0] clamp(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp

	function automatic logic [31:0] thr_max(input logic [1:0] g);
		thr_max = (g < 2'h2) ? HV_MAX_MILLI : FRQ_MAX_MILLI;
	endfunction : thr_max

	// ==========================================================
	// Bus decode
	wire        acc       = AVS_READ | AVS_WRITE;
	wire        new_req   = acc & AVS_WAITREQUEST;
	wire        wr_take   = AVS_WRITE & new_req;
	wire [1:0]  gidx      = AVS_ADDRESS[3:2];
	wire        hit_ctrl  = (AVS_ADDRESS == GRD_CTRL_OFS);
	wire        hit_stat  = (AVS_ADDRESS == GRD_STAT_OFS);
	wire        hit_clr   = (AVS_ADDRESS == GRD_CLEAR_OFS);
	wire        hit_thr   = (AVS_ADDRESS[7:4] == THR_BASE_OFS[7:4]);
	wire        hit_dly   = (AVS_ADDRESS[7:4] == DLY_BASE_OFS[7:4]);
	wire        hit_def   = (AVS_ADDRESS[7:4] == DEF_BASE_OFS[7:4]);
	wire        hit_lim   = (AVS_ADDRESS[7:5] == LIMIT_BASE_OFS[7:5]);
	wire        hit_lctl  = (AVS_ADDRESS == LOAD_CTRL_OFS);
	wire        hit_lstat = (AVS_ADDRESS == LOAD_STAT_OFS);
	wire        hit_cat   = (AVS_ADDRESS == MODE_CAT_OFS);
	wire        lim_max   = AVS_ADDRESS[4];

	// ==========================================================
	// Configuration registers
	logic [3:0]  guard_en_q;
	logic        out_en_q;
	logic [31:0] thr_q [NUM_GUARDS];
	logic [31:0] dly_q [NUM_GUARDS];
	logic        role_load_q;
	logic [1:0]  mode_q;
	logic        fast_q;
	logic [2:0]  rect_q;
	logic [3:0]  tripped;
	wire         any_trip = |tripped;
	wire  [3:0]  clr_vec  = (wr_take & hit_clr) ? AVS_WRITEDATA[3:0] : 4'h0;
	wire  [2:0]  rect_wd  = AVS_WRITEDATA[LC_RECT_LSB +: 3];
	wire         load_ok  = fit_s_q[1] & role_load_q;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			guard_en_q  <= 4'h0;
			out_en_q    <= 1'b0;
			role_load_q <= 1'b0;
			mode_q      <= RGL_MODE_CC;
			fast_q      <= 1'b0;
			rect_q      <= 3'h0;
		end else begin
			if (wr_take & hit_ctrl) begin
				guard_en_q <= AVS_WRITEDATA[GC_EN_LSB +: 4];
				// Re-enable refused while any flag stands
				out_en_q   <= AVS_WRITEDATA[GC_OUT_EN_BIT] & ~any_trip;
			end else if (any_trip) begin
				out_en_q <= 1'b0;
			end
			if (wr_take & hit_lctl) begin
				role_load_q <= AVS_WRITEDATA[LC_ROLE_BIT];
				if (load_ok) begin
					mode_q <= AVS_WRITEDATA[LC_MODE_LSB +: 2];
					fast_q <= AVS_WRITEDATA[LC_FAST_BIT];
					// Zero phase field copies bit 7 to all phases
					rect_q <= (rect_wd == 3'h0) ?
						{3{AVS_WRITEDATA[7]}} : rect_wd;
				end
			end
		end
	end

	for (genvar g = 0; g < NUM_GUARDS; g++) begin : g_cfg
		always_ff @(posedge CLK or negedge RST_B) begin
			if (!RST_B) begin
				thr_q[g] <= (g < 2) ? ((g == 0) ? HV_DEF : LV_DEF) :
					((g == 2) ? HF_DEF : LF_DEF);
				dly_q[g] <= DLY_DEF_UNITS;
			end else if (wr_take && gidx == 2'(g)) begin
				if (hit_thr)
					thr_q[g] <= clamp(AVS_WRITEDATA, 32'h0,
						thr_max(2'(g)));
				if (hit_dly)
					dly_q[g] <= clamp(AVS_WRITEDATA, DLY_MIN_UNITS,
						DLY_MAX_UNITS);
			end
		end
	end

	// ==========================================================
	// Guards
	wire [3:0] viol;
	assign viol[GUARD_HV] = volt_s2_q > thr_q[GUARD_HV];
	assign viol[GUARD_LV] = volt_s2_q < thr_q[GUARD_LV];
	assign viol[GUARD_HF] = freq_s2_q > thr_q[GUARD_HF];
	assign viol[GUARD_LF] = freq_s2_q < thr_q[GUARD_LF];

	for (genvar g = 0; g < NUM_GUARDS; g++) begin : g_guard
		rgl_guard #(.UNIT_CYC(UNIT_CYC)) u_guard (
			.clk         (CLK),
			.rst_b       (RST_B),
			.enable      (guard_en_q[g]),
			.violation   (viol[g]),
			.delay_units (dly_q[g]),
			.clear       (clr_vec[g]),
			.tripped     (tripped[g])
		);
	end

	// ==========================================================
	// Sync and load output drive
	// Tracker is slow to flag loss; FAST_SYNC_LOCKED can be selected in its place
	wire locked = fast_q ? fst_s_q[1] : trk_s_q[1];

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			OUTPUT_ENABLE     <= 1'b0;
			LOAD_ACTIVE       <= 1'b0;
			LOAD_MODE         <= RGL_MODE_CC;
			FAST_SYNC_SEL     <= 1'b0;
			RECT_EMU_EN       <= 3'h0;
			LOAD_CURRENT_ZERO <= 1'b1;
		end else begin
			OUTPUT_ENABLE     <= out_en_q & ~any_trip;
			LOAD_ACTIVE       <= load_ok;
			LOAD_MODE         <= mode_q;
			FAST_SYNC_SEL     <= fast_q;
			RECT_EMU_EN       <= rect_q & {3{load_ok}};
			LOAD_CURRENT_ZERO <= ~locked | ~load_ok;
		end
	end

	// ==========================================================
	// Read mux
	logic [31:0] rd_d;
	wire  [31:0] lim_val = lim_max ? thr_max(gidx) : HV_MIN_MILLI;
	wire  [31:0] def_val = (gidx == 2'h0) ? HV_DEF : (gidx == 2'h1) ?
		LV_DEF : (gidx == 2'h2) ? HF_DEF : LF_DEF;

	always_comb begin
		rd_d = 32'h0;
		if (hit_ctrl)
			rd_d = {23'h0, out_en_q, 4'h0, guard_en_q};
		else if (hit_stat)
			rd_d = {28'h0, tripped};
		else if (hit_thr)
			rd_d = thr_q[gidx];
		else if (hit_dly)
			rd_d = dly_q[gidx];
		else if (hit_def)
			rd_d = def_val;
		else if (hit_lim)
			rd_d = lim_val;
		else if (hit_lctl)
			rd_d = {23'h0, role_load_q, 1'b0, rect_q, 1'b0,
				fast_q, mode_q};
		else if (hit_lstat)
			rd_d = {29'h0, load_ok, locked, fit_s_q[1]};
		else if (hit_cat)
			rd_d = MODE_CATALOG;
	end

	// One wait cycle then answer; unmapped reads return zero
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0;
		end else begin
			AVS_WAITREQUEST <= ~new_req;
			if (AVS_READ & new_req)
				AVS_READDATA <= rd_d;
		end
	end

endmodule : rgl_top
`default_nettype wire

// [include/rgl_pkg.sv]
package rgl_pkg;

	// ==========================================================
	// Register map (byte addresses, one 32-bit word each)
	localparam logic [7:0] GRD_CTRL_OFS   = 8'h00;
	localparam logic [7:0] GRD_STAT_OFS   = 8'h04;
	localparam logic [7:0] GRD_CLEAR_OFS  = 8'h08;
	localparam logic [7:0] THR_BASE_OFS   = 8'h10;
	localparam logic [7:0] DLY_BASE_OFS   = 8'h20;
	localparam logic [7:0] DEF_BASE_OFS   = 8'h30;
	localparam logic [7:0] LIMIT_BASE_OFS = 8'h40;
	localparam logic [7:0] LOAD_CTRL_OFS  = 8'h60;
	localparam logic [7:0] LOAD_STAT_OFS  = 8'h64;
	localparam logic [7:0] MODE_CAT_OFS   = 8'h68;

	// ==========================================================
	// Guard indices: 0 high volt, 1 low volt, 2 high freq, 3 low freq
	localparam int NUM_GUARDS = 4;
	localparam int NUM_PHASES = 3;
	localparam int GUARD_HV   = 0;
	localparam int GUARD_LV   = 1;
	localparam int GUARD_HF   = 2;
	localparam int GUARD_LF   = 3;

	// Thresholds in milli-units (mV or mHz)
	localparam logic [31:0] HV_MIN_MILLI  = 32'h0000_0000;
	localparam logic [31:0] HV_MAX_MILLI  = 32'h0007_5300; // 480.000
	localparam logic [31:0] FRQ_MIN_MILLI = 32'h0000_0000;
	localparam logic [31:0] FRQ_MAX_MILLI = 32'h000f_4240; // 1000.000
	localparam logic [31:0] HV_DEF_MILLI  = 32'h0003_a980; // 240.000
	localparam logic [31:0] LV_DEF_MILLI  = 32'h0000_0000;
	localparam logic [31:0] HF_DEF_MILLI  = 32'h0000_fde8; // 65.000
	localparam logic [31:0] LF_DEF_MILLI  = 32'h0000_afc8; // 45.000

	// Trip delay stored in units of 100 us (0.1000 s = 1000)
	localparam int          CLK_HZ         = 100_000_000;
	localparam int          DLY_UNIT_US    = 100;
	localparam int          DLY_UNIT_CYC   = CLK_HZ / 1_000_000 * DLY_UNIT_US;
	localparam logic [31:0] DLY_MIN_UNITS  = 32'h0000_03e8; // 0.1000 s
	localparam logic [31:0] DLY_MAX_UNITS  = 32'h0001_86a0; // 10.000 s
	localparam logic [31:0] DLY_DEF_UNITS  = DLY_MIN_UNITS;

	// Load and guard control bit positions
	localparam int LC_MODE_LSB   = 0;
	localparam int LC_FAST_BIT   = 2;
	localparam int LC_RECT_LSB   = 4;
	localparam int LC_ROLE_BIT   = 8;
	localparam int GC_EN_LSB     = 0;
	localparam int GC_OUT_EN_BIT = 8;

	typedef enum logic [1:0] {
		RGL_MODE_CC = 2'h0,
		RGL_MODE_CR = 2'h1,
		RGL_MODE_CP = 2'h2,
		RGL_MODE_CE = 2'h3
	} rgl_mode_t;

	// Catalog word: four codes in ascending order, one per byte
	localparam logic [31:0] MODE_CATALOG = 32'h0302_0100;

endpackage : rgl_pkg

// [tb/rgl_plant.sv]
`timescale 1ns/1ns
`default_nettype none
module rgl_plant (
	input wire logic  clk,
	input wire logic  trk_in,
	input wire logic  fst_in,
	output logic [31:0] volt,
	output logic [31:0] freq,
	output logic      trk_lock,
	output logic      fst_lock
);
	// ==========
	// Measurements jitter every cycle but stay between default limits
	always_ff @(posedge clk) begin
		volt <= 32'h0001_cce0 + ($urandom % 32'h0000_0fa0);
		freq <= 32'h0000_c350 + ($urandom % 32'h0000_03e8);
		trk_lock <= trk_in;
		fst_lock <= fst_in;
	end
endmodule : rgl_plant
`default_nettype wire

// [tb/rgl_top_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module rgl_top_chk (
	input wire logic       CLK,
	input wire logic       RST_B,
	input wire logic       AVS_READ,
	input wire logic       AVS_WRITE,
	input wire logic       AVS_WAITREQUEST,
	input wire logic       LOAD_OPTION_FITTED,
	input wire logic       TRACKER_LOCKED,
	input wire logic       FAST_SYNC_LOCKED,
	input wire logic       OUTPUT_ENABLE,
	input wire logic       LOAD_ACTIVE,
	input wire logic [1:0] LOAD_MODE,
	input wire logic       FAST_SYNC_SEL,
	input wire logic [2:0] RECT_EMU_EN,
	input wire logic       LOAD_CURRENT_ZERO
);
	// ==========
	// Properties
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
		|=> !AVS_WAITREQUEST) else $error("bus answer late");
	a_ack_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("ack longer than one cycle");
	a_trk_zero: assert property (
		(LOAD_ACTIVE && !FAST_SYNC_SEL && !TRACKER_LOCKED)[*5]
		|-> LOAD_CURRENT_ZERO) else $error("current kept on unlock");
	a_fast_zero: assert property (
		(LOAD_ACTIVE && FAST_SYNC_SEL && !FAST_SYNC_LOCKED)[*5]
		|-> LOAD_CURRENT_ZERO) else $error("current kept fast unlock");
	a_role_zero: assert property ((!LOAD_ACTIVE)[*2] |-> LOAD_CURRENT_ZERO)
		else $error("current without load role");
	a_fit_gate: assert property ((!LOAD_OPTION_FITTED)[*5] |-> !LOAD_ACTIVE)
		else $error("load active without option");
	a_rect_gate: assert property ((!LOAD_ACTIVE)[*2] |-> RECT_EMU_EN == 3'h0)
		else $error("rectifier on outside load");
	a_out_rise: assert property ($rose(OUTPUT_ENABLE) |-> $past(AVS_WRITE))
		else $error("output on without write");
	a_mode_write: assert property ($changed(LOAD_MODE) |-> $past(AVS_WRITE))
		else $error("mode moved without write");
	c_fast: cover property (FAST_SYNC_SEL && !LOAD_CURRENT_ZERO);
	c_trk: cover property (LOAD_ACTIVE && !FAST_SYNC_SEL && LOAD_CURRENT_ZERO);
	c_rect: cover property (RECT_EMU_EN == 3'h7);
endmodule : rgl_top_chk
bind rgl_top rgl_top_chk i_rgl_top_chk (.CLK, .RST_B, .AVS_READ, .AVS_WRITE,
	.AVS_WAITREQUEST, .LOAD_OPTION_FITTED, .TRACKER_LOCKED, .FAST_SYNC_LOCKED,
	.OUTPUT_ENABLE, .LOAD_ACTIVE, .LOAD_MODE, .FAST_SYNC_SEL, .RECT_EMU_EN,
	.LOAD_CURRENT_ZERO);
`default_nettype wire

// [tb/test_rgl_top.sv]
`timescale 1ns/1ns
`default_nettype none
module test_rgl_top;
	import rgl_pkg::*;
	logic        CLK, RST_B, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
	logic        LOAD_OPTION_FITTED, TRACKER_LOCKED, FAST_SYNC_LOCKED;
	logic        OUTPUT_ENABLE, LOAD_ACTIVE, FAST_SYNC_SEL, LOAD_CURRENT_ZERO;
	logic [7:0]  AVS_ADDRESS;
	logic [1:0]  LOAD_MODE;
	logic [2:0]  RECT_EMU_EN;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, VOLT_RMS_MILLI, FREQ_MILLI, q, v;
	logic        trk, fst;
	int          num_errors, n_checks;
	int          wait_n;
	logic [31:0] dflt [4] = '{HV_DEF_MILLI, LV_DEF_MILLI, HF_DEF_MILLI,
		LF_DEF_MILLI};
	// Delay unit shortened to one cycle so a trip fits in the run
	rgl_top #(.UNIT_CYC(1)) i_rgl_top (.*);
	rgl_plant i_rgl_plant (.clk(CLK), .trk_in(trk), .fst_in(fst),
		.volt(VOLT_RMS_MILLI), .freq(FREQ_MILLI), .trk_lock(TRACKER_LOCKED),
		.fst_lock(FAST_SYNC_LOCKED));
	// ==========
	// Tasks
	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= d;
		do begin
			@(posedge CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
		if (n >= 40) begin
			num_errors++;
			close_out;
		end
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		@(posedge CLK);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, q);
	endtask : rd
	// Model of the clamping that the device applies to settings
	function automatic logic [31:0] clampv(int g, logic [31:0] x);
		logic [31:0] m;
		m = (g < 2) ? HV_MAX_MILLI : FRQ_MAX_MILLI;
		return (x > m) ? m : x;
	endfunction : clampv
	function automatic logic [31:0] clampd(logic [31:0] x);
		return (x < DLY_MIN_UNITS) ? DLY_MIN_UNITS :
			(x > DLY_MAX_UNITS) ? DLY_MAX_UNITS : x;
	endfunction : clampd
	// ==========
	// Sequence
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	initial begin
		repeat (100000) @(posedge CLK);
		num_errors++;
		close_out;
	end
	initial begin
		v = $urandom(40);
		{RST_B, AVS_READ, AVS_WRITE, LOAD_OPTION_FITTED, trk, fst} = 6'h0;
		AVS_ADDRESS = 8'h00;
		AVS_WRITEDATA = 32'h0;
		num_errors = 0;
		n_checks = 0;
		repeat (20) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		for (int g = 0; g < 4; g++) begin
			rd(DEF_BASE_OFS + 8'(4 * g), dflt[g]);
			rd(LIMIT_BASE_OFS + 8'(4 * g), 32'h0);
			rd(LIMIT_BASE_OFS + 8'(16 + 4 * g), clampv(g, 32'hffff_ffff));
			rd(DLY_BASE_OFS + 8'(4 * g), 32'h0000_03e8);
		end
		rd(GRD_STAT_OFS, 32'h0);
		rd(LOAD_CTRL_OFS, 32'h0);
		rd(MODE_CAT_OFS, 32'h0302_0100);
		rd(8'hfc, 32'h0);
		bus(1'b1, GRD_CTRL_OFS, 32'h0000_010f);
		rd(GRD_CTRL_OFS, 32'h0000_010f);
		chk("out_en", 32'h1, 32'(OUTPUT_ENABLE));
		for (int g = 0; g < 4; g++) begin
			for (int k = 0; k < 3; k++) begin
				v = (k == 0) ? $urandom : $urandom % 32'h0007_5300;
				bus(1'b1, THR_BASE_OFS + 8'(4 * g), v);
				rd(THR_BASE_OFS + 8'(4 * g), clampv(g, v));
				v = (k == 0) ? 32'h0 : (k == 1) ? $urandom : $urandom % 32'h0001_86a0;
				bus(1'b1, DLY_BASE_OFS + 8'(4 * g), v);
				rd(DLY_BASE_OFS + 8'(4 * g), clampd(v));
			end
		end
		// Guards see violations but far shorter than any delay
		rd(GRD_STAT_OFS, 32'h0);
		chk("out_en", 32'h1, 32'(OUTPUT_ENABLE));
		bus(1'b1, GRD_CLEAR_OFS, 32'h0000_000f);
		rd(GRD_STAT_OFS, 32'h0);
		bus(1'b1, LOAD_CTRL_OFS, 32'h0000_0103);
		chk("active", 32'h0, 32'(LOAD_ACTIVE));
		chk("mode", 32'h0, 32'(LOAD_MODE));
		LOAD_OPTION_FITTED <= 1'b1;
		trk <= 1'b1;
		repeat (4) @(posedge CLK);
		bus(1'b1, LOAD_CTRL_OFS, 32'h0000_0100);
		chk("active", 32'h1, 32'(LOAD_ACTIVE));
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, LOAD_CTRL_OFS, 32'h0000_0100 | 32'(m));
			rd(LOAD_CTRL_OFS, 32'h0000_0100 | 32'(m));
			chk("mode", 32'(m), 32'(LOAD_MODE));
		end
		chk("zero", 32'h0, 32'(LOAD_CURRENT_ZERO));
		trk <= 1'b0;
		repeat (6) @(posedge CLK);
		chk("zero", 32'h1, 32'(LOAD_CURRENT_ZERO));
		// Expected frequency is assumed set by the host before fast sync
		bus(1'b1, LOAD_CTRL_OFS, 32'h0000_0104);
		chk("fast", 32'h1, 32'(FAST_SYNC_SEL));
		chk("zero", 32'h1, 32'(LOAD_CURRENT_ZERO));
		repeat (6) @(posedge CLK);
		fst <= 1'b1;
		repeat (6) @(posedge CLK);
		chk("zero", 32'h0, 32'(LOAD_CURRENT_ZERO));
		bus(1'b1, LOAD_CTRL_OFS, 32'h0000_0180);
		chk("rect", 32'h7, 32'(RECT_EMU_EN));
		bus(1'b1, LOAD_CTRL_OFS, 32'h0000_0120);
		chk("rect", 32'h2, 32'(RECT_EMU_EN));
		bus(1'b1, LOAD_CTRL_OFS, 32'h0);
		chk("active", 32'h0, 32'(LOAD_ACTIVE));
		chk("rect", 32'h0, 32'(RECT_EMU_EN));
		// Park every guard inside its limits, then drive a high-volt trip
		for (int g = 0; g < 4; g++) begin
			v = (g % 2 == 1) ? 32'h0 : 32'hffff_ffff;
			bus(1'b1, THR_BASE_OFS + 8'(4 * g), v);
		end
		bus(1'b1, DLY_BASE_OFS, 32'h0);
		bus(1'b1, GRD_CLEAR_OFS, 32'h0000_000f);
		bus(1'b1, GRD_CTRL_OFS, 32'h0000_010f);
		rd(GRD_CTRL_OFS, 32'h0000_010f);
		// A violation shorter than the delay must not trip
		bus(1'b1, THR_BASE_OFS, 32'h0);
		repeat (600) @(posedge CLK);
		bus(1'b1, THR_BASE_OFS, 32'hffff_ffff);
		rd(GRD_STAT_OFS, 32'h0);
		bus(1'b1, THR_BASE_OFS, 32'h0);
		wait_n = 0;
		while (OUTPUT_ENABLE === 1'b1 && wait_n < 1100) begin
			@(posedge CLK);
			wait_n++;
		end
		// Timer restarted: trip near the 1000-cycle delay, not 400
		v = 32'(wait_n >= 998 && wait_n <= 1004);
		chk("trip_time", 32'h1, v);
		rd(GRD_STAT_OFS, 32'h1);
		bus(1'b1, THR_BASE_OFS, 32'hffff_ffff);
		rd(GRD_STAT_OFS, 32'h1);
		chk("out_en", 32'h0, 32'(OUTPUT_ENABLE));
		bus(1'b1, GRD_CTRL_OFS, 32'h0000_010f);
		rd(GRD_CTRL_OFS, 32'h0000_000f);
		bus(1'b1, GRD_CLEAR_OFS, 32'h0000_0001);
		rd(GRD_STAT_OFS, 32'h0);
		bus(1'b1, GRD_CTRL_OFS, 32'h0000_010f);
		rd(GRD_CTRL_OFS, 32'h0000_010f);
		chk("out_en", 32'h1, 32'(OUTPUT_ENABLE));
		close_out;
	end
endmodule : test_rgl_top
`default_nettype wire
